// ### sim/bbdec_chk_sva.sv
`timescale 1ns/1ps
// decode and timing checks on the decoder ports
module bbdec_chk (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic OPCODE_VALID,
  input wire logic [7:0] OPCODE,
  input wire logic [7:0] EXT_SELECT,
  input wire logic OPCODE_READY,
  input wire logic DEC_VALID,
  input wire logic [4:0] DEC_CLASS,
  input wire logic [1:0] DEC_LENGTH,
  input wire logic [2:0] DEC_MCYCLES,
  input wire logic [3:0] DEC_CLOCKS,
  input wire logic [2:0] DEC_REG_NUM,
  input wire logic [2:0] DEC_PAGE,
  input wire logic DEC_CLEARS_BIT,
  input wire logic DEC_RELATIVE,
  input wire logic DEC_CALL,
  input wire logic EXEC_DONE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  // an opcode accepted at this edge
  sequence s_take;
    OPCODE_VALID && OPCODE_READY;
  endsequence
  // a given opcode accepted
  sequence s_take_op(logic [7:0] o);
    s_take ##0 (OPCODE == o);
  endsequence
  // take followed by its decode with a given cycle count
  sequence s_dec(logic [2:0] m);
    s_take ##1 (DEC_MCYCLES == m);
  endsequence
  chk_and_carry: assert property (
    s_take_op(8'h82) |=> DEC_CLASS == bbdec_pkg::CLS_AND_BIT && DEC_LENGTH == 2'h2
      && DEC_MCYCLES == 3'h2) else $error("and-bit decode wrong");
  chk_move_carry: assert property (
    s_take_op(8'ha2) |=> DEC_CLASS == bbdec_pkg::CLS_MOVE_BIT_TO_C && DEC_LENGTH == 2'h2
      && DEC_MCYCLES == 3'h1) else $error("bit-to-carry decode wrong");
  chk_abs_page: assert property (
    s_take ##0 (OPCODE[4:0] == 5'h11) |=> DEC_CALL && DEC_PAGE == $past(OPCODE[7:5])
      && DEC_CLASS == bbdec_pkg::CLS_ABS_CALL) else $error("absolute call page wrong");
  chk_reg_field: assert property (
    s_take |=> DEC_REG_NUM == $past(OPCODE[2:0])) else $error("register number wrong");
  chk_clear_bit: assert property (
    s_take_op(8'h10) |=> DEC_CLEARS_BIT && DEC_RELATIVE && DEC_LENGTH == 2'h3)
    else $error("branch-and-clear decode wrong");
  chk_dec_reg: assert property (
    s_take ##0 (OPCODE[7:3] == 5'h1b) |=> DEC_CLASS == bbdec_pkg::CLS_DEC_REG
      && DEC_LENGTH == 2'h2) else $error("register decrement decode wrong");
  chk_ext_store: assert property (
    s_take_op(8'ha5) ##0 (EXT_SELECT[7:4] == 4'h1) |=> DEC_MCYCLES == 3'h2
      && DEC_CLASS == bbdec_pkg::CLS_CODE_STORE && DEC_LENGTH == 2'h1)
    else $error("extension store decode wrong");
  chk_clocks_double: assert property (
    DEC_VALID |-> DEC_CLOCKS == {DEC_MCYCLES, 1'b0}) else $error("clock count not doubled");
  chk_busy_two: assert property (
    s_dec(3'h2) |-> (!OPCODE_READY)[*4] ##1 (OPCODE_READY && EXEC_DONE))
    else $error("two-cycle execution time wrong");
  chk_busy_one: assert property (
    s_dec(3'h1) |-> (!OPCODE_READY)[*2] ##1 (OPCODE_READY && EXEC_DONE))
    else $error("one-cycle execution time wrong");
endmodule
bind bit_and_branch_opcode_decoder bbdec_chk u_bbdec_chk (
  .MCLK(MCLK), .RESET(RESET), .OPCODE_VALID(OPCODE_VALID), .OPCODE(OPCODE),
  .EXT_SELECT(EXT_SELECT), .OPCODE_READY(OPCODE_READY), .DEC_VALID(DEC_VALID),
  .DEC_CLASS(DEC_CLASS), .DEC_LENGTH(DEC_LENGTH), .DEC_MCYCLES(DEC_MCYCLES),
  .DEC_CLOCKS(DEC_CLOCKS), .DEC_REG_NUM(DEC_REG_NUM), .DEC_PAGE(DEC_PAGE),
  .DEC_CLEARS_BIT(DEC_CLEARS_BIT), .DEC_RELATIVE(DEC_RELATIVE), .DEC_CALL(DEC_CALL),
  .EXEC_DONE(EXEC_DONE)
);

// ### sim/fetch_model.sv
`timescale 1ns/1ps
// fetch stage: offers one opcode, holds it until the decoder takes it
module fetch_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0] go_op,
  input wire logic [7:0] go_ext,
  input wire logic [1:0] lag,
  input wire logic ready,
  output logic valid,
  output logic [7:0] op,
  output logic [7:0] ext,
  output logic taken
);
  logic pend_q; // request latched, not yet offered
  logic [1:0] wait_q; // idle cycles left before a slow offer
  logic [7:0] op_q; // opcode to offer
  logic [7:0] ext_q; // selection field to offer
  // time-zero values
  initial begin
    valid = 1'b0;
    op = 8'h00;
    ext = 8'h00;
    taken = 1'b0;
    pend_q = 1'b0;
    wait_q = 2'h0;
  end
  // offer sequencing
  always @(posedge mclk) begin
    taken <= 1'b0;
    if (rst) begin
      valid <= 1'b0;
      pend_q <= 1'b0;
    end else if (go) begin
      pend_q <= 1'b1;
      wait_q <= lag;
      op_q <= go_op;
      ext_q <= go_ext;
    end else if (pend_q && wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (pend_q) begin
      pend_q <= 1'b0;
      valid <= 1'b1;
      op <= op_q;
      ext <= ext_q;
    end else if (valid && ready) begin
      // taken: drop the offer, stop showing the old byte
      valid <= 1'b0;
      taken <= 1'b1;
      op <= ~op;
      ext <= ~ext;
    end
  end
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the bit and branch decoder
module tb_top;
  logic MCLK = 1'b0; // 25 MHz system clock
  logic RESET = 1'b1; // held for three edges
  logic go = 1'b0; // request to the fetch model
  logic [7:0] go_op = 8'h00; // opcode to fetch
  logic [7:0] esel = 8'h00; // selection field for the next offer
  logic [1:0] slow = 2'h0; // fetch delay for the next offer
  logic [7:0] go_ext = 8'h00;
  logic [1:0] lag = 2'h0;
  logic vld, rdy, dv, known, isel, ubit, cbit, ibit, rel, call, done, taken;
  logic [7:0] opc, ext;
  logic [4:0] cls;
  logic [1:0] len;
  logic [2:0] mc, rnum, page;
  logic [3:0] clks;
  int n_mismatch = 0;
  int checks = 0;
  always #20 MCLK = ~MCLK;
  bit_and_branch_opcode_decoder u_bit_and_branch_opcode_decoder (
    .MCLK(MCLK), .RESET(RESET), .OPCODE_VALID(vld), .OPCODE(opc), .EXT_SELECT(ext),
    .OPCODE_READY(rdy), .DEC_VALID(dv), .DEC_KNOWN(known), .DEC_CLASS(cls),
    .DEC_LENGTH(len), .DEC_MCYCLES(mc), .DEC_CLOCKS(clks), .DEC_REG_NUM(rnum),
    .DEC_IND_SEL(isel), .DEC_PAGE(page), .DEC_USES_BIT(ubit), .DEC_CLEARS_BIT(cbit),
    .DEC_INVERT_BIT(ibit), .DEC_RELATIVE(rel), .DEC_CALL(call), .EXEC_DONE(done));
  fetch_model u_fetch_model (
    .mclk(MCLK), .rst(RESET), .go(go), .go_op(go_op), .go_ext(go_ext), .lag(lag),
    .ready(rdy), .valid(vld), .op(opc), .ext(ext), .taken(taken));
  // compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // hand one opcode to the fetch model
  task automatic offer(input logic [7:0] o);
    @(posedge MCLK);
    go <= 1'b1;
    go_op <= o;
    go_ext <= esel;
    lag <= slow;
    @(posedge MCLK);
    go <= 1'b0;
  endtask
  // wait for the take, n counts the edges waited
  task automatic wait_take(output int n);
    n = 0;
    do begin
      @(posedge MCLK);
      #1;
      n++;
    end while (taken !== 1'b1 && n < 40);
  endtask
  // one opcode: decode fields, then execution time to done
  task automatic run(input logic [7:0] o, input logic [4:0] c, input logic [1:0] l,
                     input logic [2:0] m);
    int n;
    logic [5:0] f; // expected known, bit use, clear, invert, relative, call
    offer(o);
    wait_take(n);
    chk("valid", dv, 8'h01);
    chk("class", cls, c);
    chk("length", len, l);
    chk("mcycles", mc, m);
    chk("clocks", clks, {m, 1'b0});
    chk("reg", rnum, o[2:0]);
    chk("ind", isel, o[0]);
    chk("page", page, o[7:5]);
    // flags follow from what each class does
    f[5] = (c != bbdec_pkg::CLS_NONE);
    f[4] = c inside {bbdec_pkg::CLS_AND_BIT, bbdec_pkg::CLS_AND_NBIT, bbdec_pkg::CLS_OR_BIT,
                     bbdec_pkg::CLS_OR_NBIT, bbdec_pkg::CLS_MOVE_BIT_TO_C,
                     bbdec_pkg::CLS_MOVE_C_TO_BIT, bbdec_pkg::CLS_BIT_SET,
                     bbdec_pkg::CLS_BIT_CLEAR, bbdec_pkg::CLS_BIT_SET_CLR};
    f[3] = (c == bbdec_pkg::CLS_BIT_SET_CLR);
    f[2] = c inside {bbdec_pkg::CLS_AND_NBIT, bbdec_pkg::CLS_OR_NBIT};
    f[1] = c inside {bbdec_pkg::CLS_SHORT_JUMP, bbdec_pkg::CLS_BIT_SET,
                     bbdec_pkg::CLS_BIT_CLEAR, bbdec_pkg::CLS_BIT_SET_CLR,
                     bbdec_pkg::CLS_ACC_ZERO, bbdec_pkg::CLS_ACC_NONZERO,
                     bbdec_pkg::CLS_CMP_ACC_DIR, bbdec_pkg::CLS_CMP_ACC_IMM,
                     bbdec_pkg::CLS_CMP_REG_IMM, bbdec_pkg::CLS_CMP_IND_IMM,
                     bbdec_pkg::CLS_DEC_REG, bbdec_pkg::CLS_DEC_DIR};
    f[0] = c inside {bbdec_pkg::CLS_ABS_CALL, bbdec_pkg::CLS_LONG_CALL};
    chk("flags", {2'h0, known, ubit, cbit, ibit, rel, call}, {2'h0, f});
    n = 0;
    do begin
      @(posedge MCLK);
      #1;
      n++;
    end while (done !== 1'b1 && n < 20);
    chk("exec time", 8'(n), {m, 1'b0});
    chk("ready", rdy, 8'h01);
  endtask
  // carry and bit group
  task automatic t_bool;
    run(8'h82, bbdec_pkg::CLS_AND_BIT, 2'h2, 3'h2);
    run(8'hb0, bbdec_pkg::CLS_AND_NBIT, 2'h2, 3'h2);
    run(8'h72, bbdec_pkg::CLS_OR_BIT, 2'h2, 3'h2);
    run(8'ha0, bbdec_pkg::CLS_OR_NBIT, 2'h2, 3'h2);
    run(8'ha2, bbdec_pkg::CLS_MOVE_BIT_TO_C, 2'h2, 3'h1);
    run(8'h92, bbdec_pkg::CLS_MOVE_C_TO_BIT, 2'h2, 3'h2);
    $display("bool test done");
  endtask
  // jumps, calls and single branches
  task automatic t_branch;
    for (int k = 0; k < 8; k++) begin
      run({k[2:0], 5'h11}, bbdec_pkg::CLS_ABS_CALL, 2'h2, 3'h2);
      run({k[2:0], 5'h01}, bbdec_pkg::CLS_ABS_JUMP, 2'h2, 3'h2);
    end
    run(8'h12, bbdec_pkg::CLS_LONG_CALL, 2'h3, 3'h2);
    run(8'h02, bbdec_pkg::CLS_LONG_JUMP, 2'h3, 3'h2);
    run(8'h80, bbdec_pkg::CLS_SHORT_JUMP, 2'h2, 3'h2);
    run(8'h20, bbdec_pkg::CLS_BIT_SET, 2'h3, 3'h2);
    run(8'h30, bbdec_pkg::CLS_BIT_CLEAR, 2'h3, 3'h2);
    run(8'h10, bbdec_pkg::CLS_BIT_SET_CLR, 2'h3, 3'h2);
    run(8'h73, bbdec_pkg::CLS_JUMP_INDIRECT, 2'h1, 3'h2);
    run(8'h60, bbdec_pkg::CLS_ACC_ZERO, 2'h2, 3'h2);
    run(8'h70, bbdec_pkg::CLS_ACC_NONZERO, 2'h2, 3'h2);
    run(8'hb5, bbdec_pkg::CLS_CMP_ACC_DIR, 2'h3, 3'h2);
    run(8'hb4, bbdec_pkg::CLS_CMP_ACC_IMM, 2'h3, 3'h2);
    $display("branch test done");
  endtask
  // register families and their edges
  task automatic t_regs;
    for (int k = 0; k < 8; k++) begin
      run(8'hb8 + 8'(k), bbdec_pkg::CLS_CMP_REG_IMM, 2'h3, 3'h2);
      run(8'hd8 + 8'(k), bbdec_pkg::CLS_DEC_REG, 2'h2, 3'h2);
    end
    run(8'hb6, bbdec_pkg::CLS_CMP_IND_IMM, 2'h3, 3'h2);
    run(8'hb7, bbdec_pkg::CLS_CMP_IND_IMM, 2'h3, 3'h2);
    run(8'hd5, bbdec_pkg::CLS_DEC_DIR, 2'h3, 3'h2);
    $display("register test done");
  endtask
  // extension opcode under each selection, fetched slowly
  task automatic t_ext;
    slow = 2'h3;
    esel = 8'h1f;
    run(8'ha5, bbdec_pkg::CLS_CODE_STORE, 2'h1, 3'h2);
    esel = 8'h0f;
    run(8'ha5, bbdec_pkg::CLS_BREAKPOINT, 2'h1, 3'h1);
    esel = 8'hf1;
    run(8'ha5, bbdec_pkg::CLS_BREAKPOINT, 2'h1, 3'h1);
    slow = 2'h0;
    esel = 8'h00;
    $display("extension test done");
  endtask
  // offer arriving while busy must wait for ready
  task automatic t_refuse;
    int n;
    offer(8'h92);
    wait_take(n);
    offer(8'ha2);
    wait_take(n);
    chk("refused wait", 8'(n), 8'h03);
    chk("class", cls, bbdec_pkg::CLS_MOVE_BIT_TO_C);
    repeat (3) @(posedge MCLK);
    $display("refusal test done");
  endtask
  // opcodes outside these groups pass as one byte, one cycle
  task automatic t_other;
    run(8'h00, bbdec_pkg::CLS_NONE, 2'h1, 3'h1);
    run(8'h40, bbdec_pkg::CLS_NONE, 2'h1, 3'h1);
    $display("other opcode test done");
  endtask
  // reset in mid-execution clears results and frees the decoder
  task automatic t_reset;
    int n;
    offer(8'h12);
    wait_take(n);
    @(posedge MCLK);
    RESET <= 1'b1;
    @(posedge MCLK);
    RESET <= 1'b0;
    #1;
    chk("reset ready", rdy, 8'h01);
    chk("reset valid", dv, 8'h00);
    chk("reset class", cls, 8'h00);
    chk("reset clocks", clks, 8'h00);
    chk("reset done", done, 8'h00);
    run(8'h82, bbdec_pkg::CLS_AND_BIT, 2'h2, 3'h2);
    $display("reset test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge MCLK);
    RESET <= 1'b0;
    @(posedge MCLK);
    #1;
    chk("idle ready", rdy, 8'h01);
    t_bool;
    t_branch;
    t_regs;
    t_ext;
    t_refuse;
    t_other;
    t_reset;
    tally_and_finish;
  end
  // watchdog: about five times the expected run of some 500 cycles
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule

// ### verilog/bbdec_cycle_count.sv
`timescale 1ns/1ps
// converts machine cycles to clocks and times the execution
module bbdec_cycle_count (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [2:0] mcycles,
  output logic busy,
  output logic done,
  output logic [3:0] clocks
);
  logic [3:0] cnt_q; // clocks left
  logic [3:0] cnt_d;
  logic done_q;

  // clock count is machine cycles doubled
  always_comb begin
    clocks = 4'(mcycles * bbdec_pkg::CLOCKS_PER_MC);
  end

  // next counter value
  always_comb begin
    cnt_d = cnt_q;
    if (start && cnt_q == 4'h0) begin
      cnt_d = clocks; // load the doubled count
    end else if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1; // one clock passes
    end
  end

  // countdown register
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // finish pulse when the last clock ends
  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == 4'h1);
    end
  end

  assign busy = (cnt_q != 4'h0);
  assign done = done_q;
endmodule

// ### verilog/bbdec_field_split.sv
`timescale 1ns/1ps
// extracts operand fields packed into an opcode
module bbdec_field_split (
  input wire logic [7:0] opcode,
  output logic [2:0] reg_num,
  output logic ind_sel,
  output logic [2:0] page
);
  // register number from the three low bits
  assign reg_num = opcode[bbdec_pkg::REG_MSB:0];
  // indirect register pick from bit 0
  assign ind_sel = opcode[bbdec_pkg::IND_BIT];
  // upper address bits from the top three bits
  assign page = opcode[bbdec_pkg::PAGE_MSB:bbdec_pkg::PAGE_LSB];
endmodule

// ### verilog/bbdec_pkg.sv
package bbdec_pkg;
  // instruction classes decoded by this block
  typedef enum logic [4:0] {
    CLS_NONE = 5'h00,
    CLS_AND_BIT = 5'h01,
    CLS_AND_NBIT = 5'h02,
    CLS_OR_BIT = 5'h03,
    CLS_OR_NBIT = 5'h04,
    CLS_MOVE_BIT_TO_C = 5'h05,
    CLS_MOVE_C_TO_BIT = 5'h06,
    CLS_ABS_CALL = 5'h07,
    CLS_ABS_JUMP = 5'h08,
    CLS_LONG_CALL = 5'h09,
    CLS_LONG_JUMP = 5'h0a,
    CLS_SHORT_JUMP = 5'h0b,
    CLS_BIT_SET = 5'h0c,
    CLS_BIT_CLEAR = 5'h0d,
    CLS_BIT_SET_CLR = 5'h0e,
    CLS_JUMP_INDIRECT = 5'h0f,
    CLS_ACC_ZERO = 5'h10,
    CLS_ACC_NONZERO = 5'h11,
    CLS_CMP_ACC_DIR = 5'h12,
    CLS_CMP_ACC_IMM = 5'h13,
    CLS_CMP_REG_IMM = 5'h14,
    CLS_CMP_IND_IMM = 5'h15,
    CLS_DEC_REG = 5'h16,
    CLS_DEC_DIR = 5'h17,
    CLS_CODE_STORE = 5'h18,
    CLS_BREAKPOINT = 5'h19
  } instr_class_t;

  // opcode values
  localparam logic [7:0] OP_AND_BIT = 8'h82;
  localparam logic [7:0] OP_AND_NBIT = 8'hb0;
  localparam logic [7:0] OP_OR_BIT = 8'h72;
  localparam logic [7:0] OP_OR_NBIT = 8'ha0;
  localparam logic [7:0] OP_MOVE_BIT_TO_C = 8'ha2;
  localparam logic [7:0] OP_MOVE_C_TO_BIT = 8'h92;
  localparam logic [7:0] OP_LONG_CALL = 8'h12;
  localparam logic [7:0] OP_LONG_JUMP = 8'h02;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] OP_BIT_SET = 8'h20;
  localparam logic [7:0] OP_BIT_CLEAR = 8'h30;
  localparam logic [7:0] OP_BIT_SET_CLR = 8'h10;
  localparam logic [7:0] OP_JUMP_INDIRECT = 8'h73;
  localparam logic [7:0] OP_ACC_ZERO = 8'h60;
  localparam logic [7:0] OP_ACC_NONZERO = 8'h70;
  localparam logic [7:0] OP_CMP_ACC_DIR = 8'hb5;
  localparam logic [7:0] OP_CMP_ACC_IMM = 8'hb4;
  localparam logic [7:0] OP_EXTENSION = 8'ha5;
  // low-bit and high-bit patterns of opcode families
  localparam logic [4:0] ABS_CALL_LOW = 5'h11;
  localparam logic [4:0] ABS_JUMP_LOW = 5'h01;
  localparam logic [4:0] CMP_REG_HIGH = 5'h17;
  localparam logic [6:0] CMP_IND_HIGH = 7'h5b;
  localparam logic [4:0] DEC_REG_HIGH = 5'h1b;
  localparam logic [7:0] OP_DEC_DIR = 8'hd5;

  // field positions
  localparam int REG_MSB = 2;
  localparam int IND_BIT = 0;
  localparam int PAGE_MSB = 7;
  localparam int PAGE_LSB = 5;
  localparam int ABS_LOW_MSB = 4;
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 4;

  // extension select nibble that picks the code store meaning
  localparam logic [3:0] SEL_CODE_STORE = 4'h1;

  // lengths and machine cycle counts
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [2:0] MC_ONE = 3'h1;
  localparam logic [2:0] MC_TWO = 3'h2;
  localparam int CLOCKS_PER_MC = 2;
endpackage

// ### verilog/bit_and_branch_opcode_decoder.sv
`timescale 1ns/1ps
// Behaviour
// - 82 ands bit into carry, 2B 2MC
// - B0 ands inverse bit into carry, 2B 2MC
// - 72 ors bit into carry, 2B 2MC
// - A0 ors inverse bit into carry, 2B 2MC
// - A2 copies bit to carry, 2B 1MC
// - 92 copies carry to bit, 2B 2MC
// - x1 families are absolute call/jump, 2B 2MC
// - 12 long call, 02 long jump, 3B 2MC
// - 80 short relative jump, 2B 2MC
// - 20 branches if bit set, 3B 2MC
// - 30 branches if bit clear, 3B 2MC
// - 10 branches on set bit, clears it
// - 73 jumps accumulator plus pointer, 1B 2MC
// - 60/70 branch on accumulator zero/nonzero, 2B
// - B5/B4 compare accumulator, branch unequal, 3B
// - B8-BF, B6-B7 compare immediate, 3B 2MC
// - D8-DF 2B, D5 3B decrement branch nonzero
// - register number from three low bits
// - top three bits give address page
// - A5 meaning picked by extension select nibble
// - one machine cycle equals two clocks
module bit_and_branch_opcode_decoder (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic OPCODE_VALID,
  input wire logic [7:0] OPCODE,
  input wire logic [7:0] EXT_SELECT,
  output logic OPCODE_READY,
  output logic DEC_VALID,
  output logic DEC_KNOWN,
  output logic [4:0] DEC_CLASS,
  output logic [1:0] DEC_LENGTH,
  output logic [2:0] DEC_MCYCLES,
  output logic [3:0] DEC_CLOCKS,
  output logic [2:0] DEC_REG_NUM,
  output logic DEC_IND_SEL,
  output logic [2:0] DEC_PAGE,
  output logic DEC_USES_BIT,
  output logic DEC_CLEARS_BIT,
  output logic DEC_INVERT_BIT,
  output logic DEC_RELATIVE,
  output logic DEC_CALL,
  output logic EXEC_DONE
);
  // class picked by the combinational decode
  bbdec_pkg::instr_class_t cls_d;
  // opcode belongs to the bit or branch groups
  logic known_d;
  // instruction length in bytes
  logic [1:0] len_d;
  // execution time in machine cycles
  logic [2:0] mc_d;
  // opcode reads or writes an addressed bit
  logic uses_bit_d;
  // opcode clears the addressed bit after testing it
  logic clears_bit_d;
  // opcode works on the inverse of the addressed bit
  logic invert_bit_d;
  // opcode branches by a relative offset
  logic relative_d;
  // opcode saves a return address
  logic call_d;
  // register number field from the splitter
  logic [2:0] reg_num_w;
  // indirect register pick from the splitter
  logic ind_sel_w;
  // upper destination address bits from the splitter
  logic [2:0] page_w;
  // doubled cycle count from the timer
  logic [3:0] clocks_w;
  // timer still counting the previous opcode
  logic busy_w;
  // timer finish pulse
  logic done_w;
  // opcode accepted at this edge
  logic take;
  // result strobe register
  logic valid_q;
  // registered group membership
  logic known_q;
  // registered class code
  logic [4:0] class_q;
  // registered length
  logic [1:0] len_q;
  // registered machine cycles
  logic [2:0] mc_q;
  // registered clock count
  logic [3:0] clocks_q;
  // registered register number
  logic [2:0] reg_num_q;
  // registered indirect pick
  logic ind_sel_q;
  // registered address page
  logic [2:0] page_q;
  // registered bit flags
  logic uses_bit_q;
  logic clears_bit_q;
  logic invert_bit_q;
  // registered branch kind flags
  logic relative_q;
  logic call_q;

  // opcode field extraction
  bbdec_field_split u_fields (
    .opcode(OPCODE),
    .reg_num(reg_num_w),
    .ind_sel(ind_sel_w),
    .page(page_w)
  );

  // execution timer in clocks
  bbdec_cycle_count u_timer (
    .clk(MCLK),
    .rst(RESET),
    .start(take),
    .mcycles(mc_d),
    .busy(busy_w),
    .done(done_w),
    .clocks(clocks_w)
  );

  // new opcode accepted only when the timer is idle
  assign OPCODE_READY = !busy_w;
  assign take = OPCODE_VALID && !busy_w;

  // main opcode decode
  always_comb begin
    cls_d = bbdec_pkg::CLS_NONE;
    known_d = 1'b1;
    len_d = bbdec_pkg::LEN_TWO;
    mc_d = bbdec_pkg::MC_TWO;
    uses_bit_d = 1'b0;
    clears_bit_d = 1'b0;
    invert_bit_d = 1'b0;
    relative_d = 1'b0;
    call_d = 1'b0;
    if (OPCODE[bbdec_pkg::ABS_LOW_MSB:0] == bbdec_pkg::ABS_CALL_LOW) begin
      // x1 call family, page in the top bits
      cls_d = bbdec_pkg::CLS_ABS_CALL;
      call_d = 1'b1;
    end else if (OPCODE[bbdec_pkg::ABS_LOW_MSB:0] == bbdec_pkg::ABS_JUMP_LOW) begin
      // x1 jump family, page in the top bits
      cls_d = bbdec_pkg::CLS_ABS_JUMP;
    end else if (OPCODE[bbdec_pkg::PAGE_MSB:bbdec_pkg::REG_MSB + 1]
                 == bbdec_pkg::CMP_REG_HIGH) begin
      // register compare, register number in the low bits
      cls_d = bbdec_pkg::CLS_CMP_REG_IMM;
      len_d = bbdec_pkg::LEN_THREE;
      relative_d = 1'b1;
    end else if (OPCODE[bbdec_pkg::PAGE_MSB:bbdec_pkg::IND_BIT + 1]
                 == bbdec_pkg::CMP_IND_HIGH) begin
      // indirect compare, pointer pick in the lowest bit
      cls_d = bbdec_pkg::CLS_CMP_IND_IMM;
      len_d = bbdec_pkg::LEN_THREE;
      relative_d = 1'b1;
    end else if (OPCODE[bbdec_pkg::PAGE_MSB:bbdec_pkg::REG_MSB + 1]
                 == bbdec_pkg::DEC_REG_HIGH) begin
      // register decrement, two bytes only
      cls_d = bbdec_pkg::CLS_DEC_REG;
      relative_d = 1'b1;
    end else begin
      // single opcodes matched exactly
      unique case (OPCODE)
        bbdec_pkg::OP_AND_BIT: begin
          cls_d = bbdec_pkg::CLS_AND_BIT;
          uses_bit_d = 1'b1;
        end
        bbdec_pkg::OP_AND_NBIT: begin
          cls_d = bbdec_pkg::CLS_AND_NBIT;
          uses_bit_d = 1'b1;
          invert_bit_d = 1'b1;
        end
        bbdec_pkg::OP_OR_BIT: begin
          cls_d = bbdec_pkg::CLS_OR_BIT;
          uses_bit_d = 1'b1;
        end
        bbdec_pkg::OP_OR_NBIT: begin
          cls_d = bbdec_pkg::CLS_OR_NBIT;
          uses_bit_d = 1'b1;
          invert_bit_d = 1'b1;
        end
        bbdec_pkg::OP_MOVE_BIT_TO_C: begin
          cls_d = bbdec_pkg::CLS_MOVE_BIT_TO_C;
          mc_d = bbdec_pkg::MC_ONE;
          uses_bit_d = 1'b1;
        end
        bbdec_pkg::OP_MOVE_C_TO_BIT: begin
          cls_d = bbdec_pkg::CLS_MOVE_C_TO_BIT;
          uses_bit_d = 1'b1;
        end
        bbdec_pkg::OP_LONG_CALL: begin
          cls_d = bbdec_pkg::CLS_LONG_CALL;
          len_d = bbdec_pkg::LEN_THREE;
          call_d = 1'b1;
        end
        bbdec_pkg::OP_LONG_JUMP: begin
          cls_d = bbdec_pkg::CLS_LONG_JUMP;
          len_d = bbdec_pkg::LEN_THREE;
        end
        bbdec_pkg::OP_SHORT_JUMP: begin
          cls_d = bbdec_pkg::CLS_SHORT_JUMP;
          relative_d = 1'b1;
        end
        bbdec_pkg::OP_BIT_SET: begin
          cls_d = bbdec_pkg::CLS_BIT_SET;
          len_d = bbdec_pkg::LEN_THREE;
          uses_bit_d = 1'b1;
          relative_d = 1'b1;
        end
        bbdec_pkg::OP_BIT_CLEAR: begin
          cls_d = bbdec_pkg::CLS_BIT_CLEAR;
          len_d = bbdec_pkg::LEN_THREE;
          uses_bit_d = 1'b1;
          relative_d = 1'b1;
        end
        bbdec_pkg::OP_BIT_SET_CLR: begin
          cls_d = bbdec_pkg::CLS_BIT_SET_CLR;
          len_d = bbdec_pkg::LEN_THREE;
          uses_bit_d = 1'b1;
          clears_bit_d = 1'b1;
          relative_d = 1'b1;
        end
        bbdec_pkg::OP_JUMP_INDIRECT: begin
          cls_d = bbdec_pkg::CLS_JUMP_INDIRECT;
          len_d = bbdec_pkg::LEN_ONE;
        end
        bbdec_pkg::OP_ACC_ZERO: begin
          cls_d = bbdec_pkg::CLS_ACC_ZERO;
          relative_d = 1'b1;
        end
        bbdec_pkg::OP_ACC_NONZERO: begin
          cls_d = bbdec_pkg::CLS_ACC_NONZERO;
          relative_d = 1'b1;
        end
        bbdec_pkg::OP_CMP_ACC_DIR: begin
          cls_d = bbdec_pkg::CLS_CMP_ACC_DIR;
          len_d = bbdec_pkg::LEN_THREE;
          relative_d = 1'b1;
        end
        bbdec_pkg::OP_CMP_ACC_IMM: begin
          cls_d = bbdec_pkg::CLS_CMP_ACC_IMM;
          len_d = bbdec_pkg::LEN_THREE;
          relative_d = 1'b1;
        end
        bbdec_pkg::OP_DEC_DIR: begin
          cls_d = bbdec_pkg::CLS_DEC_DIR;
          len_d = bbdec_pkg::LEN_THREE;
          relative_d = 1'b1;
        end
        bbdec_pkg::OP_EXTENSION: begin
          // meaning follows the extension select nibble
          len_d = bbdec_pkg::LEN_ONE;
          if (EXT_SELECT[bbdec_pkg::SEL_MSB:bbdec_pkg::SEL_LSB]
              == bbdec_pkg::SEL_CODE_STORE) begin
            cls_d = bbdec_pkg::CLS_CODE_STORE;
          end else begin
            cls_d = bbdec_pkg::CLS_BREAKPOINT;
            mc_d = bbdec_pkg::MC_ONE;
          end
        end
        default: begin
          // opcode outside these groups
          known_d = 1'b0;
          len_d = bbdec_pkg::LEN_ONE;
          mc_d = bbdec_pkg::MC_ONE;
        end
      endcase
    end
  end

  // one-cycle result strobe
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= take;
    end
  end

  // decoded result, held until the next accepted opcode
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      known_q <= 1'b0;
      class_q <= 5'h00;
      len_q <= 2'h0;
      mc_q <= 3'h0;
      clocks_q <= 4'h0;
      uses_bit_q <= 1'b0;
      clears_bit_q <= 1'b0;
      invert_bit_q <= 1'b0;
      relative_q <= 1'b0;
      call_q <= 1'b0;
    end else if (take) begin
      known_q <= known_d;
      class_q <= cls_d;
      len_q <= len_d;
      mc_q <= mc_d;
      clocks_q <= clocks_w;
      uses_bit_q <= uses_bit_d;
      clears_bit_q <= clears_bit_d;
      invert_bit_q <= invert_bit_d;
      relative_q <= relative_d;
      call_q <= call_d;
    end
  end

  // packed operand fields, held with the result
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      reg_num_q <= 3'h0;
      ind_sel_q <= 1'b0;
      page_q <= 3'h0;
    end else if (take) begin
      reg_num_q <= reg_num_w;
      ind_sel_q <= ind_sel_w;
      page_q <= page_w;
    end
  end

  // result strobe, one cycle after the take
  assign DEC_VALID = valid_q;
  // group membership of the last opcode
  assign DEC_KNOWN = known_q;
  // class code of the last opcode
  assign DEC_CLASS = class_q;
  // byte count of the last opcode
  assign DEC_LENGTH = len_q;
  // machine cycles of the last opcode
  assign DEC_MCYCLES = mc_q;
  // system clocks of the last opcode
  assign DEC_CLOCKS = clocks_q;
  // working register number
  assign DEC_REG_NUM = reg_num_q;
  // indirect register pick
  assign DEC_IND_SEL = ind_sel_q;
  // upper destination address bits
  assign DEC_PAGE = page_q;
  // addressed bit is an operand
  assign DEC_USES_BIT = uses_bit_q;
  // addressed bit is cleared
  assign DEC_CLEARS_BIT = clears_bit_q;
  // addressed bit is taken inverted
  assign DEC_INVERT_BIT = invert_bit_q;
  // branch by relative offset
  assign DEC_RELATIVE = relative_q;
  // subroutine call
  assign DEC_CALL = call_q;
  // end of the execution time
  assign EXEC_DONE = done_w;
endmodule
